// [logic/relay_command_queue_sequencer.sv]
`timescale 1ns/1ps
`include "relay_seq_defs.svh"

// What this block does
// - each written command, bank address and pattern, is stored in a queue
// - bus acknowledge goes active once the command sits in the queue
// - on the same edge that acknowledges, the bus side tells the drain side to start
// - while the queue is not empty, pop entries and pulse coils for 7 ms
// - keep popping entries until the active-low empty flag shows none left
// - interrupt is raised on empty, only after the last pulse ended
// - one interrupt per command list, never one per relay
// - after any reset every relay bank is driven open
// - coils are unpowered whenever no switching pulse is running
module relay_command_queue_sequencer
  import relay_seq_pkg::*;
#(
  parameter int PULSE_CYCLES = `RQ_PULSE_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic WR_STROBE_N,
  input wire logic [`RQ_BANK_W-1:0] WR_BANK,
  input wire logic [`RQ_DATA_W-1:0] WR_DATA,
  output logic DTACK_N,
  output logic IRQ_N,
  input wire logic IRQ_ACK_N,
  output logic COIL_FIRE,
  output logic [`RQ_BANK_W-1:0] COIL_BANK,
  output logic [`RQ_DATA_W-1:0] COIL_PATTERN
);
  localparam logic [`RQ_CNT_W-1:0] PULSE_LAST = `RQ_CNT_W'(PULSE_CYCLES - 1);
  localparam logic [`RQ_BANK_W-1:0] LAST_BANK = `RQ_BANK_W'(`RQ_NUM_BANKS - 1);

  // three-stage synchronisers; a change counts when stages two and three agree
  logic [2:0] stb_sync_ff;
  logic [2:0] ack_sync_ff;
  logic strobe_act_ff;
  logic iack_act_ff;
  logic iack_prev_ff;

  logic acked_ff;
  logic drain_go_ff;
  logic list_active_ff;
  logic irq_ff;
  logic fire_ff;
  logic clearing_ff;
  logic [`RQ_BANK_W-1:0] clear_bank_ff;
  logic [`RQ_BANK_W-1:0] bank_ff;
  logic [`RQ_DATA_W-1:0] pattern_ff;
  logic [`RQ_CNT_W-1:0] pulse_cnt_ff;
  seq_state_t state_ff;
  seq_state_t nxt_state;

  wire q_empty_n;
  wire q_full;
  wire [`RQ_BANK_W-1:0] q_bank;
  wire [`RQ_DATA_W-1:0] q_data;

  wire push = strobe_act_ff && !acked_ff && !q_full;
  wire pop = (state_ff == ST_LOAD);
  wire pulse_end = (state_ff == ST_PULSE) && (pulse_cnt_ff == PULSE_LAST);
  wire start_list = (state_ff == ST_IDLE) && drain_go_ff && q_empty_n;
  wire list_done = (state_ff == ST_GAP) && !clearing_ff && !q_empty_n;
  wire irq_set = list_done && list_active_ff;
  wire iack_rise = iack_act_ff && !iack_prev_ff;

  cmd_queue u_queue (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .ce(CLK_EN),
    .push(push),
    .pop(pop),
    .wr_bank(WR_BANK),
    .wr_data(WR_DATA),
    .rd_bank(q_bank),
    .rd_data(q_data),
    .empty_n(q_empty_n),
    .full(q_full)
  );

  assign DTACK_N = !acked_ff;
  assign IRQ_N = !irq_ff;
  assign COIL_FIRE = fire_ff;
  assign COIL_BANK = bank_ff;
  assign COIL_PATTERN = pattern_ff;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      stb_sync_ff <= 3'h7;
      ack_sync_ff <= 3'h7;
      strobe_act_ff <= 1'b0;
      iack_act_ff <= 1'b0;
      iack_prev_ff <= 1'b0;
    end else if (CLK_EN) begin
      stb_sync_ff <= {stb_sync_ff[1:0], WR_STROBE_N};
      ack_sync_ff <= {ack_sync_ff[1:0], IRQ_ACK_N};
      if (stb_sync_ff[1] == stb_sync_ff[2]) strobe_act_ff <= !stb_sync_ff[2];
      if (ack_sync_ff[1] == ack_sync_ff[2]) iack_act_ff <= !ack_sync_ff[2];
      iack_prev_ff <= iack_act_ff;
    end
  end

  // acknowledge holds until the commander releases its strobe; a full queue
  // simply stretches the bus cycle instead of dropping the command
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      acked_ff <= 1'b0;
      drain_go_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (CLK_EN) begin
      if (push) acked_ff <= 1'b1;
      else if (!strobe_act_ff) acked_ff <= 1'b0;
      if (push) drain_go_ff <= 1'b1;
      else if (start_list) drain_go_ff <= 1'b0;
      if (irq_set) irq_ff <= 1'b1;
      else if (iack_rise) irq_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_CLEAR: nxt_state = ST_PULSE;
      ST_IDLE: if (start_list) nxt_state = ST_LOAD;
      ST_LOAD: nxt_state = ST_PULSE;
      ST_PULSE: if (pulse_end) nxt_state = ST_GAP;
      ST_GAP: begin
        if (clearing_ff) nxt_state = (clear_bank_ff == LAST_BANK) ? ST_IDLE : ST_CLEAR;
        else if (q_empty_n) nxt_state = ST_LOAD;
        else nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_CLEAR;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_ff <= ST_CLEAR;
      clearing_ff <= 1'b1;
      clear_bank_ff <= '0;
      list_active_ff <= 1'b0;
      fire_ff <= 1'b0;
      bank_ff <= '0;
      pattern_ff <= '0;
      pulse_cnt_ff <= '0;
    end else if (CLK_EN) begin
      state_ff <= nxt_state;
      fire_ff <= (nxt_state == ST_PULSE);
      if (state_ff == ST_PULSE) pulse_cnt_ff <= pulse_cnt_ff + 1'b1;
      else pulse_cnt_ff <= '0;
      if (state_ff == ST_CLEAR) begin
        bank_ff <= clear_bank_ff;
        pattern_ff <= '0;
      end
      if (pop) begin
        bank_ff <= q_bank;
        pattern_ff <= q_data;
      end
      if (state_ff == ST_GAP && clearing_ff) begin
        if (clear_bank_ff == LAST_BANK) clearing_ff <= 1'b0;
        else clear_bank_ff <= clear_bank_ff + 1'b1;
      end
      if (start_list) list_active_ff <= 1'b1;
      else if (list_done) list_active_ff <= 1'b0;
    end
  end

  // clock enable low freezes the sequencer, so checks pause with it
  sequence s_pulse_starts;
    $rose(fire_ff) && state_ff == ST_PULSE;
  endsequence

  sequence s_pulse_ends;
    state_ff == ST_PULSE && pulse_cnt_ff == PULSE_LAST;
  endsequence

  a_store_then_ack: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    $fell(DTACK_N) |-> $past(push))
    else $error("acknowledge without a stored command");

  a_push_stores: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    push |=> q_empty_n)
    else $error("accepted command not held in the queue");

  a_ack_wakes_drain: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    push |=> drain_go_ff && !DTACK_N)
    else $error("stored command did not wake the drain side");

  a_pulse_length: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    s_pulse_starts |-> pulse_cnt_ff == '0)
    else $error("coil pulse did not start from a zero count");

  a_pulse_stops: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    s_pulse_ends |=> !COIL_FIRE && state_ff == ST_GAP)
    else $error("coil pulse did not end after its full length");

  a_bank_held: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    COIL_FIRE && $past(COIL_FIRE) |-> $stable(COIL_PATTERN) && $stable(COIL_BANK))
    else $error("bank pattern changed during a pulse");

  a_drain_continues: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    state_ff == ST_GAP && !clearing_ff && q_empty_n |=> state_ff == ST_LOAD)
    else $error("queue not drained while entries remain");

  a_irq_after_last: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    $fell(IRQ_N) |-> !COIL_FIRE && !$past(q_empty_n) && !$past(COIL_FIRE))
    else $error("interrupt before the final pulse ended");

  a_one_irq: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    irq_set |=> !list_active_ff && state_ff == ST_IDLE)
    else $error("command list not closed after its interrupt");

  a_clear_opens: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    COIL_FIRE && clearing_ff |-> COIL_PATTERN == '0 && COIL_BANK == clear_bank_ff)
    else $error("reset clearing drove a relay closed");

  a_coils_idle: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    state_ff != ST_PULSE |-> !COIL_FIRE)
    else $error("coil driven outside a pulse");

  a_pulse_gap: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    $fell(COIL_FIRE) |-> !COIL_FIRE [*2])
    else $error("next pulse started without a gap");
endmodule : relay_command_queue_sequencer

// [logic/relay_seq_defs.svh]
`ifndef RELAY_SEQ_DEFS_SVH
`define RELAY_SEQ_DEFS_SVH

`define RQ_BANK_W 4
`define RQ_DATA_W 16
`define RQ_NUM_BANKS 16
`define RQ_QUEUE_DEPTH 16
`define RQ_PTR_W 4
`define RQ_CNT_W 19
`define RQ_PULSE_MS 7
`define RQ_CLK_KHZ 50000
`define RQ_PULSE_CYCLES (`RQ_PULSE_MS * `RQ_CLK_KHZ)
`define RQ_STATE_RST 5'h01

`endif

// [logic/relay_seq_pkg.sv]
`include "relay_seq_defs.svh"

package relay_seq_pkg;

  typedef enum logic [4:0] {
    ST_CLEAR = 5'h01,
    ST_IDLE = 5'h02,
    ST_LOAD = 5'h04,
    ST_PULSE = 5'h08,
    ST_GAP = 5'h10
  } seq_state_t;

endpackage : relay_seq_pkg

// [logic/cmd_queue.sv]
`timescale 1ns/1ps
`include "relay_seq_defs.svh"

module cmd_queue (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic push,
  input wire logic pop,
  input wire logic [`RQ_BANK_W-1:0] wr_bank,
  input wire logic [`RQ_DATA_W-1:0] wr_data,
  output logic [`RQ_BANK_W-1:0] rd_bank,
  output logic [`RQ_DATA_W-1:0] rd_data,
  output logic empty_n,
  output logic full
);
  logic [`RQ_BANK_W+`RQ_DATA_W-1:0] mem [`RQ_QUEUE_DEPTH];
  logic [`RQ_PTR_W-1:0] wr_ptr_ff;
  logic [`RQ_PTR_W-1:0] rd_ptr_ff;
  logic [`RQ_PTR_W:0] count_ff;
  wire do_push = push && !full;
  wire do_pop = pop && empty_n;

  assign empty_n = (count_ff != '0);
  assign full = (count_ff == (`RQ_PTR_W+1)'(`RQ_QUEUE_DEPTH));
  assign {rd_bank, rd_data} = mem[rd_ptr_ff];

  always_ff @(posedge clk) begin
    if (ce && do_push) begin
      mem[wr_ptr_ff] <= {wr_bank, wr_data};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else if (ce) begin
      if (do_push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (do_pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (do_push && !do_pop) count_ff <= count_ff + 1'b1;
      else if (do_pop && !do_push) count_ff <= count_ff - 1'b1;
    end
  end
endmodule : cmd_queue

// [sim/cmdr_model.sv]
`timescale 1ns/1ps
`include "relay_seq_defs.svh"

module cmdr_model (
  input wire logic clk,
  output logic strobe_n,
  output logic [`RQ_BANK_W-1:0] bank,
  output logic [`RQ_DATA_W-1:0] data,
  input wire logic dtack_n,
  input wire logic irq_n,
  output logic irq_ack_n
);
  initial begin
    strobe_n = 1'b1;
    bank = '0;
    data = '0;
    irq_ack_n = 1'b1;
  end

  // lat counts edges from strobe low until acknowledge seen; 0 means hung
  task automatic write(input logic [3:0] b, input logic [15:0] d, output int lat);
    int n;
    lat = 0;
    n = 0;
    @(posedge clk);
    strobe_n <= 1'b0;
    bank <= b;
    data <= d;
    do begin
      @(posedge clk);
      lat++;
    end while (dtack_n !== 1'b0 && lat < 500);
    if (lat >= 500) lat = 0;
    // released lines show the inverse so stale values are never mistaken for data
    strobe_n <= 1'b1;
    bank <= ~b;
    data <= ~d;
    do begin
      @(posedge clk);
      n++;
    end while (dtack_n !== 1'b1 && n < 50);
    if (n >= 50) lat = 0;
  endtask : write

  task automatic ack();
    int w;
    // wait up to 50 cycles for an interrupt to be pending, then answer even if none came
    w = 0;
    while (irq_n !== 1'b0 && w < 50) begin
      @(posedge clk);
      w++;
    end
    @(posedge clk);
    irq_ack_n <= 1'b0;
    repeat (8) @(posedge clk);
    irq_ack_n <= 1'b1;
  endtask : ack
endmodule : cmdr_model

// [sim/tb_top.sv]
`timescale 1ns/1ps
`include "relay_seq_defs.svh"

module tb_top;
  localparam int PULSE = 20;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  int lat_list[3] = '{1, 4, 2};
  logic strobe_n, dtack_n, irq_n, irq_ack_n, coil_fire, fire_q, irq_q;
  logic [3:0] wbank, cbank;
  logic [15:0] wdata, cpat;
  logic [19:0] exp_q[$];
  logic [19:0] e;
  int failures = 0;
  int check_count = 0;
  int len = 0;
  int since = 0;
  int irq_cnt = 0;
  int lat, t;

  always #10 sys_clk = ~sys_clk;

  cmdr_model cmdr (.clk(sys_clk), .strobe_n(strobe_n), .bank(wbank), .data(wdata),
    .dtack_n(dtack_n), .irq_n(irq_n), .irq_ack_n(irq_ack_n));

  relay_command_queue_sequencer #(.PULSE_CYCLES(PULSE)) dut (.SYS_CLK(sys_clk),
    .SYS_RST(sys_rst), .CLK_EN(clk_en), .WR_STROBE_N(strobe_n), .WR_BANK(wbank),
    .WR_DATA(wdata), .DTACK_N(dtack_n), .IRQ_N(irq_n), .IRQ_ACK_N(irq_ack_n),
    .COIL_FIRE(coil_fire), .COIL_BANK(cbank), .COIL_PATTERN(cpat));

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    check_count++;
    if (seen !== expv) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : chk

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  // reference: every pulse pops the oldest expected entry
  always @(posedge sys_clk) begin
    // frozen cycles do not count towards pulse length or gaps
    if (!sys_rst && clk_en === 1'b1) begin
      if (coil_fire === 1'b1) begin
        if (fire_q !== 1'b1) begin
          chk(exp_q.size() > 0, 1);
          if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk({cbank, cpat}, e);
          end
        end
        len++;
      end else if (fire_q === 1'b1) begin
        chk(len, PULSE);
        len = 0;
      end
      if (fire_q === 1'b1 && coil_fire === 1'b0) since = 0;
      else since++;
      if (irq_q === 1'b1 && irq_n === 1'b0) begin
        irq_cnt++;
        chk(since, 1);
      end
    end
    fire_q = coil_fire;
    irq_q = irq_n;
  end

  task automatic wait_irq();
    t = 0;
    while (irq_n !== 1'b0 && t < 2000) begin
      @(posedge sys_clk);
      t++;
    end
    if (t >= 2000) begin
      failures++;
      conclude();
    end
  endtask : wait_irq

  initial begin
    void'($urandom(32'h0124b13a));
    for (int i = 0; i < 16; i++) exp_q.push_back({4'(i), 16'h0000});
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t = 0;
    while ((exp_q.size() > 0 || coil_fire !== 1'b0) && t < 3000) begin
      @(posedge sys_clk);
      t++;
    end
    chk(t < 3000, 1);
    chk(exp_q.size(), 0);
    repeat (10) @(posedge sys_clk);
    chk(irq_cnt, 0);
    $display("test open sweep done");
    foreach (lat_list[l]) begin
      irq_cnt = 0;
      for (int k = 0; k < lat_list[l]; k++) begin
        e = 20'($urandom);
        exp_q.push_back(e);
        cmdr.write(e[19:16], e[15:0], lat);
        chk(lat, 6);
      end
      if (lat_list[l] == 2) begin
        // freeze one cycle before the first pulse ends; its length must still be whole
        clk_en <= 1'b0;
        repeat (15) @(posedge sys_clk);
        clk_en <= 1'b1;
      end
      wait_irq();
      chk(exp_q.size(), 0);
      repeat (10) @(posedge sys_clk);
      chk(irq_cnt, 1);
      chk(irq_n, 0);
      cmdr.ack();
      repeat (10) @(posedge sys_clk);
      chk(irq_n, 1);
      $display("test list of %0d done", lat_list[l]);
    end
    conclude();
  end
endmodule : tb_top
